/* File: design/atlc_pkg.sv */
// Constants, field layouts and carrier types of the auto-reload timer
// Notes on behaviour
// - Sixteen-bit counter built from two byte registers
// - Full wrap reloads pair, sets high flag
// - Timer enable requests interrupt on full overflow
// - Low-byte enable adds low-byte wrap interrupts
// - Unsplit clock: sysclk, sysclk/12, external/8
// - Divided oscillator clocks synchronised to sysclk
// - Suspend overflow wakes device, counting continues
// - Sync status high three ticks after a wake not caused by the timer
// - Oscillator-divided clock counts only with divider one
// - Split: two bytes reload from own registers
// - Split: run gates high byte only
// - Per-byte sysclk select else shared source field
// - Split: each byte wrap sets its flag
// - Split interrupts: high always, low when enabled
// - Overflow flags cleared only by software
// - Capture: oscillator falling edge copies count, sets flag
// - Control register at 0x91, resets to zero
package atlc_pkg;

	// Register addresses on the plain register port
	localparam logic [7:0] ATLC_ADDR_CTRL = 8'h91;
	localparam logic [7:0] ATLC_ADDR_RELOAD_LOW = 8'h92;
	localparam logic [7:0] ATLC_ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ATLC_ADDR_COUNT_LOW = 8'h94;
	localparam logic [7:0] ATLC_ADDR_COUNT_HIGH = 8'h95;
	localparam logic [7:0] ATLC_ADDR_CLKCTL = 8'h8e;
	localparam logic [7:0] ATLC_ADDR_IRQEN = 8'he6;
	localparam logic [7:0] ATLC_ADDR_OSCCTL = 8'hb2;

	// Bit positions in the side registers
	localparam int ATLC_BIT_HIGH_SYS = 7;
	localparam int ATLC_BIT_LOW_SYS = 6;
	localparam int ATLC_BIT_IRQ_EN = 7;
	localparam int ATLC_BIT_SYNC = 4;

	// Reset values
	localparam logic [7:0] ATLC_CTRL_RESET = 8'h00;
	localparam logic [15:0] ATLC_WORD_RESET = 16'h0000;

	// Counter extremes
	localparam logic [15:0] ATLC_ALL_ONES16 = 16'hffff;
	localparam logic [7:0] ATLC_ALL_ONES8 = 8'hff;
	localparam logic [7:0] ATLC_BYTE_ZERO = 8'h00;

	// Clock dividers and wake sync length in timer ticks
	localparam int ATLC_SYSCLK_DIV = 12;
	localparam int ATLC_OSC_DIV = 8;
	localparam int ATLC_DIV_W = 8;
	localparam logic [1:0] ATLC_SYNC_TICKS = 2'h3;

	// Shared clock source field encodings
	typedef enum logic [1:0] {
		ATLC_SRC_DIV12 = 2'b00,
		ATLC_SRC_EXT8 = 2'b01,
		ATLC_SRC_RSVD = 2'b10,
		ATLC_SRC_LFO = 2'b11
	} atlc_src_t;

	// Control register, bit 7 down to bit 0
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_byte_irq_enable;
		logic osc_capture_enable;
		logic split_mode_select;
		logic run_control;
		logic [1:0] clock_source_field;
	} atlc_ctrl_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} atlc_bus_t;

	// Whole state of the timer core
	typedef struct packed {
		atlc_ctrl_t ctrl;
		logic [15:0] count;
		logic [15:0] reload;
		logic high_byte_sysclk_select;
		logic low_byte_sysclk_select;
		logic irq_en;
		logic [3:0] div12;
		logic sync_busy;
		logic [1:0] sync_cnt;
		logic susp_d;
		logic wake;
		logic irq;
		logic [7:0] rdata;
	} atlc_state_t;

	// Whole state of one oscillator tick generator
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [ATLC_DIV_W-1:0] div;
		logic tick;
		logic fall;
	} atlc_sync_t;

endpackage

/* File: design/atlc_tick_gen.sv */
// Pin synchroniser with divide-by-N tick and falling edge pulse
`timescale 1ns/10ps
`default_nettype none
module atlc_tick_gen import atlc_pkg::*; #(
	parameter int DIV = ATLC_OSC_DIV
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic tick,
	output logic fall
);

	atlc_sync_t st; // Registered state
	atlc_sync_t next_st; // Next state

	// Synchronise, detect edges, divide rising edges
	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		next_st.tick = 1'b0;
		next_st.fall = st.prev & ~st.s2;
		if (st.s2 && !st.prev) begin
			// One rising edge of the oscillator
			if (st.div == ATLC_DIV_W'(DIV - 1)) begin
				next_st.div = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.div = st.div + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
	assign fall = st.fall;

endmodule
`default_nettype wire

/* File: design/atlc_timer.sv */
// Auto-reload timer core with split mode, capture and suspend wake
`timescale 1ns/10ps
`default_nettype none
module atlc_timer import atlc_pkg::*; #(
	parameter int SYS_DIV = ATLC_SYSCLK_DIV,
	parameter int OSC_DIV = ATLC_OSC_DIV
) (
	input wire logic clock,
	input wire logic rst,
	input wire atlc_bus_t bus,
	output logic [7:0] rdata,
	input wire logic ext_osc_in,
	input wire logic lfo_in,
	input wire logic lfo_div_is_one,
	input wire logic suspend,
	output logic irq_request,
	output logic wake_request,
	output logic suspend_sync_status
);

	atlc_state_t st; // Registered state
	atlc_state_t next_st; // Next state
	logic ext_tick; // External oscillator divided tick
	logic lfo_tick; // Low-frequency oscillator divided tick
	logic lfo_fall; // Falling edge of the oscillator
	logic t12; // Sysclk divided by twelve tick
	logic lfo_ok; // Oscillator tick gated by divider setting
	logic tl; // Low byte clock enable
	logic th; // High byte clock enable
	logic ov_l; // Low byte wrap this cycle
	logic ov_h; // High byte or full wrap this cycle
	logic cap; // Capture this cycle

	// External oscillator divided by eight
	atlc_tick_gen #(.DIV(OSC_DIV)) u_ext (
		.clock(clock),
		.rst(rst),
		.pin(ext_osc_in),
		.tick(ext_tick),
		.fall()
	);

	// Low-frequency oscillator divided by eight, plus falling edge
	atlc_tick_gen #(.DIV(OSC_DIV)) u_lfo (
		.clock(clock),
		.rst(rst),
		.pin(lfo_in),
		.tick(lfo_tick),
		.fall(lfo_fall)
	);

	// Pick the clock enable of one byte
	function automatic logic sel_tick(input logic sys_sel,
			input logic [1:0] src, input logic d12, input logic dext,
			input logic dlfo);
		logic r;
		r = 1'b0;
		if (sys_sel) begin
			r = 1'b1;
		end else begin
			case (atlc_src_t'(src))
				ATLC_SRC_DIV12: r = d12;
				ATLC_SRC_EXT8: r = dext;
				ATLC_SRC_LFO: r = dlfo;
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	// True when a byte is at all ones
	function automatic logic at_top8(input logic [7:0] v);
		return v == ATLC_ALL_ONES8;
	endfunction

	// Counting, capture, register port and status
	always_comb begin
		next_st = st;
		ov_l = 1'b0;
		ov_h = 1'b0;
		cap = 1'b0;
		// Sysclk prescaler
		t12 = st.div12 == 4'(SYS_DIV - 1);
		if (t12) begin
			next_st.div12 = '0;
		end else begin
			next_st.div12 = st.div12 + 1'b1;
		end
		lfo_ok = lfo_tick & lfo_div_is_one;
		tl = sel_tick(st.low_byte_sysclk_select,
			st.ctrl.clock_source_field, t12, ext_tick, lfo_ok);
		th = sel_tick(st.high_byte_sysclk_select,
			st.ctrl.clock_source_field, t12, ext_tick, lfo_ok);
		if (!st.ctrl.split_mode_select) begin
			// One 16-bit counter clocked by the low byte select
			if (st.ctrl.run_control && tl) begin
				if (st.count == ATLC_ALL_ONES16) begin
					next_st.count = st.reload;
					ov_h = 1'b1;
				end else begin
					next_st.count = st.count + 16'h0001;
				end
				ov_l = at_top8(st.count[7:0]);
			end
		end else begin
			// Low byte always runs in split mode
			if (tl) begin
				if (at_top8(st.count[7:0])) begin
					next_st.count[7:0] = st.reload[7:0];
					ov_l = 1'b1;
				end else begin
					next_st.count[7:0] = st.count[7:0] + 8'h01;
				end
			end
			// High byte gated by run
			if (st.ctrl.run_control && th) begin
				if (at_top8(st.count[15:8])) begin
					next_st.count[15:8] = st.reload[15:8];
					ov_h = 1'b1;
				end else begin
					next_st.count[15:8] = st.count[15:8] + 8'h01;
				end
			end
		end
		// Oscillator capture into the reload pair
		if (st.ctrl.osc_capture_enable && lfo_fall) begin
			next_st.reload = st.count;
			cap = 1'b1;
		end
		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				ATLC_ADDR_CTRL: next_st.ctrl = atlc_ctrl_t'(bus.wdata);
				ATLC_ADDR_RELOAD_LOW: next_st.reload[7:0] = bus.wdata;
				ATLC_ADDR_RELOAD_HIGH: next_st.reload[15:8] = bus.wdata;
				ATLC_ADDR_COUNT_LOW: next_st.count[7:0] = bus.wdata;
				ATLC_ADDR_COUNT_HIGH: next_st.count[15:8] = bus.wdata;
				ATLC_ADDR_CLKCTL: begin
					next_st.high_byte_sysclk_select =
						bus.wdata[ATLC_BIT_HIGH_SYS];
					next_st.low_byte_sysclk_select =
						bus.wdata[ATLC_BIT_LOW_SYS];
				end
				ATLC_ADDR_IRQEN: next_st.irq_en = bus.wdata[ATLC_BIT_IRQ_EN];
				default: ;
			endcase
		end
		// Hardware set wins over a clearing write in the same cycle
		if (ov_h || cap) begin
			next_st.ctrl.high_overflow_flag = 1'b1;
		end
		if (ov_l) begin
			next_st.ctrl.low_overflow_flag = 1'b1;
		end
		// Interrupt request follows flags and enables
		next_st.irq = next_st.irq_en &
			(next_st.ctrl.high_overflow_flag |
			(next_st.ctrl.low_byte_irq_enable &
			next_st.ctrl.low_overflow_flag));
		// Wake on counter overflow while suspended
		next_st.susp_d = suspend;
		if (suspend && (ov_h || (st.ctrl.split_mode_select && ov_l))) begin
			next_st.wake = 1'b1;
		end else if (!suspend) begin
			next_st.wake = 1'b0;
		end
		// Sync status after a wake not caused by the timer
		if (st.susp_d && !suspend && !st.wake) begin
			next_st.sync_busy = 1'b1;
			next_st.sync_cnt = ATLC_SYNC_TICKS;
		end else if (st.sync_busy && (tl || th)) begin
			if (st.sync_cnt == 2'h1) begin
				next_st.sync_busy = 1'b0;
			end
			next_st.sync_cnt = st.sync_cnt - 2'h1;
		end
		// Read data stands only in the cycle after the strobe
		next_st.rdata = ATLC_BYTE_ZERO;
		if (bus.rd) begin
			case (bus.addr)
				ATLC_ADDR_CTRL: next_st.rdata = st.ctrl;
				ATLC_ADDR_RELOAD_LOW: next_st.rdata = st.reload[7:0];
				ATLC_ADDR_RELOAD_HIGH: next_st.rdata = st.reload[15:8];
				ATLC_ADDR_COUNT_LOW: next_st.rdata = st.count[7:0];
				ATLC_ADDR_COUNT_HIGH: next_st.rdata = st.count[15:8];
				ATLC_ADDR_CLKCTL: begin
					next_st.rdata[ATLC_BIT_HIGH_SYS] =
						st.high_byte_sysclk_select;
					next_st.rdata[ATLC_BIT_LOW_SYS] =
						st.low_byte_sysclk_select;
				end
				ATLC_ADDR_IRQEN: next_st.rdata[ATLC_BIT_IRQ_EN] = st.irq_en;
				ATLC_ADDR_OSCCTL: next_st.rdata[ATLC_BIT_SYNC] = st.sync_busy;
				default: next_st.rdata = ATLC_BYTE_ZERO;
			endcase
		end
	end

	// State register, control register resets to zero
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.ctrl <= atlc_ctrl_t'(ATLC_CTRL_RESET);
			st.count <= ATLC_WORD_RESET;
			st.reload <= ATLC_WORD_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign rdata = st.rdata;
	assign irq_request = st.irq;
	assign wake_request = st.wake;
	assign suspend_sync_status = st.sync_busy;

	// Full wrap reloads the pair
	property p_wrap16;
		@(posedge clock) disable iff (rst)
		(!st.ctrl.split_mode_select && st.ctrl.run_control && tl &&
		st.count == ATLC_ALL_ONES16 && !bus.wr)
		|=> (st.count == $past(st.reload));
	endproperty
	a_wrap16: assert property (p_wrap16)
		else $error("full wrap did not reload the counter");

	// Overflow raises the high flag one cycle later
	property p_flag_high;
		@(posedge clock) disable iff (rst)
		(ov_h || cap) |=> st.ctrl.high_overflow_flag;
	endproperty
	a_flag_high: assert property (p_flag_high)
		else $error("high flag not set after overflow");

	// Stopped unsplit counter holds
	property p_hold;
		@(posedge clock) disable iff (rst)
		(!st.ctrl.split_mode_select && !st.ctrl.run_control && !bus.wr)
		|=> $stable(st.count);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter moved while stopped");

	// Split low byte counts with run cleared
	property p_split_low;
		@(posedge clock) disable iff (rst)
		(st.ctrl.split_mode_select && !st.ctrl.run_control && tl &&
		!at_top8(st.count[7:0]) && !bus.wr)
		|=> (st.count[7:0] == $past(st.count[7:0]) + 8'h01) &&
		$stable(st.count[15:8]);
	endproperty
	a_split_low: assert property (p_split_low)
		else $error("split low byte did not count alone");

	// Interrupt output matches flags and enables
	property p_irq;
		@(posedge clock) disable iff (rst)
		irq_request == (st.irq_en && (st.ctrl.high_overflow_flag ||
		(st.ctrl.low_byte_irq_enable && st.ctrl.low_overflow_flag)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request disagrees with flags");

	// High flag only falls by a control write
	property p_sticky;
		@(posedge clock) disable iff (rst)
		(st.ctrl.high_overflow_flag &&
		!(bus.wr && bus.addr == ATLC_ADDR_CTRL))
		|=> st.ctrl.high_overflow_flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("high flag cleared by hardware");

	// Capture copies the count
	property p_capture;
		@(posedge clock) disable iff (rst)
		(st.ctrl.osc_capture_enable && lfo_fall && !bus.wr)
		|=> (st.reload == $past(st.count)) && st.ctrl.high_overflow_flag;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not copy the counter");

	// Reserved source leaves the low byte still
	property p_reserved;
		@(posedge clock) disable iff (rst)
		(st.ctrl.clock_source_field == ATLC_SRC_RSVD &&
		!st.low_byte_sysclk_select && !bus.wr)
		|=> $stable(st.count[7:0]);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved source advanced the low byte");

	// Foreign wake raises sync status for at least one cycle
	property p_sync;
		@(posedge clock) disable iff (rst)
		(st.susp_d && !suspend && !st.wake) |=> suspend_sync_status;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync status missing after foreign wake");

	// Overflow in suspend raises wake
	property p_wake;
		@(posedge clock) disable iff (rst)
		(suspend && ov_h) |=> wake_request;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake after suspended overflow");

	// Oscillator source stalls with wrong divider
	property p_lfo_div;
		@(posedge clock) disable iff (rst)
		(!lfo_div_is_one && !st.ctrl.split_mode_select &&
		st.ctrl.clock_source_field == ATLC_SRC_LFO &&
		!st.low_byte_sysclk_select && !bus.wr)
		|=> $stable(st.count);
	endproperty
	a_lfo_div: assert property (p_lfo_div)
		else $error("counter ran with oscillator divider not one");

	// Control read returns the register
	property p_read_ctrl;
		@(posedge clock) disable iff (rst)
		(bus.rd && bus.addr == ATLC_ADDR_CTRL) |=> rdata == $past(st.ctrl);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl)
		else $error("control read returned wrong data");

	// Main scenarios
	c_wrap16: cover property (@(posedge clock) disable iff (rst)
		ov_h && !st.ctrl.split_mode_select);
	c_split_low: cover property (@(posedge clock) disable iff (rst)
		ov_l && st.ctrl.split_mode_select);
	c_capture: cover property (@(posedge clock) disable iff (rst) cap);
	c_wake: cover property (@(posedge clock) disable iff (rst)
		suspend && !wake_request ##1 wake_request);

endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench of the auto-reload timer core
`timescale 1ns/10ps
`default_nettype none
module tb import atlc_pkg::*; ;

	// Clock, reset and design ports
	logic clock = 1'b0;
	logic rst;
	atlc_bus_t bus;
	logic [7:0] rdata;
	logic ext_osc_in;
	logic lfo_in;
	logic lfo_div_is_one;
	logic suspend;
	logic irq_request;
	logic wake_request;
	logic suspend_sync_status;
	// Result counters and interrupt enable mirror
	int err_count = 0;
	int check_count = 0;
	logic irq_on;
	logic [15:0] val;

	// 50 MHz system clock
	always #10 clock = ~clock;

	// Timer under test
	atlc_timer #(.SYS_DIV(12), .OSC_DIV(8)) uut (
		.clock(clock),
		.rst(rst),
		.bus(bus),
		.rdata(rdata),
		.ext_osc_in(ext_osc_in),
		.lfo_in(lfo_in),
		.lfo_div_is_one(lfo_div_is_one),
		.suspend(suspend),
		.irq_request(irq_request),
		.wake_request(wake_request),
		.suspend_sync_status(suspend_sync_status)
	);

	// Byte compare
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Word compare
	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single bit compare
	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits whole cycles, ending just after an edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One-cycle write strobe
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Read and compare one register
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		bus_rd(a, v);
		check8(v, exp);
	endtask

	// Write and read a low/high register pair
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		bus_wr(a, d[7:0]);
		bus_wr(a + 8'h01, d[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		bus_rd(a, d[7:0]);
		bus_rd(a + 8'h01, d[15:8]);
	endtask

	// Six sysclk ticks from start to stop; flags read mid-run
	task automatic run_case(input logic [15:0] cnt, input logic [7:0] ctl,
			input logic [7:0] exp_ctl, input logic [15:0] exp_cnt);
		wr16(ATLC_ADDR_COUNT_LOW, cnt);
		bus_wr(ATLC_ADDR_CTRL, ctl);
		wait_cyc(2);
		rd_chk(ATLC_ADDR_CTRL, exp_ctl);
		check1(irq_request, irq_on & (exp_ctl[7] | (exp_ctl[5] & exp_ctl[6])));
		bus_wr(ATLC_ADDR_CTRL, 8'h00);
		rd16(ATLC_ADDR_COUNT_LOW, val);
		check16(val, exp_cnt);
	endtask

	// Count divided-clock ticks from zero over 16 rising pin edges
	task automatic src_case(input logic [7:0] ctl, input logic low_frequency_oscillator,
			input logic [15:0] lo, input logic [15:0] hi);
		wr16(ATLC_ADDR_COUNT_LOW, 16'h0000);
		bus_wr(ATLC_ADDR_CTRL, ctl);
		repeat (16) begin
			wait_cyc(4);
			if (low_frequency_oscillator) lfo_in <= 1'b1;
			else ext_osc_in <= 1'b1;
			wait_cyc(4);
			if (low_frequency_oscillator) lfo_in <= 1'b0;
			else ext_osc_in <= 1'b0;
		end
		wait_cyc(8);
		bus_wr(ATLC_ADDR_CTRL, 8'h00);
		rd16(ATLC_ADDR_COUNT_LOW, val);
		if (lo == hi) check16(val, lo);
		else check1((val >= lo) && (val <= hi), 1'b1);
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		wait_cyc(20000);
		err_count++;
		summarize();
	end

	// Main sequence
	initial begin
		bus = '0;
		rst = 1'b1;
		ext_osc_in = 1'b0;
		lfo_in = 1'b0;
		lfo_div_is_one = 1'b1;
		suspend = 1'b0;
		irq_on = 1'b0;
		wait_cyc(8);
		rst <= 1'b0;
		// Reset values, unmapped and read-only places
		rd_chk(ATLC_ADDR_CTRL, ATLC_CTRL_RESET);
		rd_chk(ATLC_ADDR_RELOAD_LOW, 8'h00);
		rd_chk(ATLC_ADDR_COUNT_HIGH, 8'h00);
		rd_chk(ATLC_ADDR_OSCCTL, 8'h00);
		bus_wr(8'h00, 8'h5a);
		rd_chk(8'h00, 8'h00);
		bus_wr(ATLC_ADDR_OSCCTL, 8'hff);
		rd_chk(ATLC_ADDR_OSCCTL, 8'h00);
		wr16(ATLC_ADDR_RELOAD_LOW, 16'h1234);
		rd16(ATLC_ADDR_RELOAD_LOW, val);
		check16(val, 16'h1234);
		bus_wr(ATLC_ADDR_CLKCTL, 8'hc0);
		rd_chk(ATLC_ADDR_CLKCTL, 8'hc0);
		bus_wr(ATLC_ADDR_IRQEN, 8'h80);
		irq_on = 1'b1;
		// Modes on the system clock
		run_case(16'hfffe, 8'h04, 8'hc4, 16'h1238);
		run_case(16'h00fe, 8'h24, 8'h64, 16'h0104);
		run_case(16'h00fe, 8'h00, 8'h00, 16'h00fe);
		run_case(16'h10fe, 8'h08, 8'h48, 16'h1038);
		run_case(16'hfefe, 8'h0c, 8'hcc, 16'h1638);
		run_case(16'h10fe, 8'h2c, 8'h6c, 16'h1638);
		bus_wr(ATLC_ADDR_IRQEN, 8'h00);
		irq_on = 1'b0;
		run_case(16'hfffe, 8'h04, 8'hc4, 16'h1238);
		// Divided clock sources
		bus_wr(ATLC_ADDR_CLKCTL, 8'h00);
		src_case(8'h05, 1'b0, 16'h0002, 16'h0002);
		src_case(8'h06, 1'b0, 16'h0000, 16'h0000);
		src_case(8'h04, 1'b0, 16'h000b, 16'h000c);
		lfo_div_is_one <= 1'b0;
		src_case(8'h07, 1'b1, 16'h0000, 16'h0000);
		lfo_div_is_one <= 1'b1;
		src_case(8'h07, 1'b1, 16'h0002, 16'h0002);
		// Capture of the count on an oscillator falling edge
		bus_wr(ATLC_ADDR_CLKCTL, 8'hc0);
		wr16(ATLC_ADDR_COUNT_LOW, 16'h0000);
		bus_wr(ATLC_ADDR_CTRL, 8'h14);
		wait_cyc(2);
		lfo_in <= 1'b1;
		wait_cyc(4);
		lfo_in <= 1'b0;
		wait_cyc(10);
		rd_chk(ATLC_ADDR_CTRL, 8'h94);
		bus_wr(ATLC_ADDR_CTRL, 8'h00);
		rd16(ATLC_ADDR_RELOAD_LOW, val);
		check1((val >= 16'h0005) && (val <= 16'h000c), 1'b1);
		// Overflow in suspend raises wake
		wr16(ATLC_ADDR_COUNT_LOW, 16'hfffe);
		suspend <= 1'b1;
		bus_wr(ATLC_ADDR_CTRL, 8'h04);
		wait_cyc(4);
		#1 check1(wake_request, 1'b1);
		bus_wr(ATLC_ADDR_CTRL, 8'h00);
		suspend <= 1'b0;
		wait_cyc(3);
		#1 check1(wake_request, 1'b0);
		check1(suspend_sync_status, 1'b0);
		// Wake from elsewhere holds sync status a few ticks
		suspend <= 1'b1;
		wait_cyc(3);
		suspend <= 1'b0;
		wait_cyc(2);
		#1 check1(suspend_sync_status, 1'b1);
		wait_cyc(10);
		#1 check1(suspend_sync_status, 1'b0);
		rd_chk(ATLC_ADDR_OSCCTL, 8'h00);
		summarize();
	end

endmodule
`default_nettype wire
